// *** design/it12_interval_timer.sv ***
// Purpose: 12-bit interval timer with peripheral clock gate
// Assumes: the count clock is a pin from another domain, sampled in sys_clk_i
// Notes: the gated count clock is modelled as gated count ticks
`timescale 1ns/1ns
module it12_interval_timer #(
  parameter logic [19:0] PER_ADDR = it12_pkg::PER_ADDR_DEFAULT // gate register address
) (
  input wire logic sys_clk_i, // cpu clock, 100 MHz
  input wire logic resetn_i, // async reset, active low
  input wire logic cnt_clk_i, // low-speed count clock
  input wire it12_pkg::it12_sfr_req_t sfr_req_i, // cpu register access
  output logic [15:0] sfr_rdata_o, // read data, one cycle after rd
  output logic low_speed_peripheral_clock_gate_o, // timer clock-gate bit
  output logic count_run_enable_o, // applied run enable
  output logic interval_interrupt_request_o // one-cycle match pulse
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] peripheral_clock_gates;
  logic [7:0] next_peripheral_clock_gates;
  it12_pkg::it12_ctrl_t ctrl;
  it12_pkg::it12_ctrl_t next_ctrl;
  logic [it12_pkg::CMP_W-1:0] count;
  logic [it12_pkg::CMP_W-1:0] next_count;
  logic irq;
  logic next_irq;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic raw_tick;
  logic tick;
  logic gate;
  logic wr_per;
  logic wr_ctrl;
  logic match;

  // ---------------------------------------------------------------
  // count clock tick
  // ---------------------------------------------------------------
  it12_tick_sync u_tick_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .cnt_clk_i(cnt_clk_i),
    .tick_o(raw_tick)
  );

  // clock gate and write decode
  assign gate = peripheral_clock_gates[it12_pkg::GATE_BIT];
  assign tick = raw_tick & gate; // no count clock while gated off
  assign wr_per = sfr_req_i.wr && (sfr_req_i.addr == PER_ADDR);
  assign wr_ctrl = sfr_req_i.wr && (sfr_req_i.addr == it12_pkg::CTRL_WORD_ADDR) && gate;
  assign match = (count == ctrl.cmp);

  // ---------------------------------------------------------------
  // peripheral clock gates register
  // ---------------------------------------------------------------
  // software keeps bits 1, 3, 4 and 6 at zero; they are stored as written
  always_comb begin
    next_peripheral_clock_gates = peripheral_clock_gates;
    if (wr_per) begin
      next_peripheral_clock_gates = sfr_req_i.wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      peripheral_clock_gates <= it12_pkg::PER_RESET;
    end else begin
      peripheral_clock_gates <= next_peripheral_clock_gates;
    end
  end

  // ---------------------------------------------------------------
  // interval control word
  // ---------------------------------------------------------------
  // run enable is taken into effect and into read-back on the next count tick
  always_comb begin
    next_ctrl = ctrl;
    if (!gate) begin
      next_ctrl.run_applied = it12_pkg::RUN_RESET; // held in reset
      next_ctrl.run_written = it12_pkg::RUN_RESET;
      next_ctrl.cmp = it12_pkg::CMP_RESET;
    end else begin
      if (wr_ctrl) begin
        next_ctrl.run_written = sfr_req_i.wdata[it12_pkg::RUN_BIT];
        next_ctrl.cmp = sfr_req_i.wdata[it12_pkg::CMP_W-1:0];
      end
      if (tick) begin
        next_ctrl.run_applied = ctrl.run_written; // one count cycle late
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl.run_applied <= it12_pkg::RUN_RESET;
      ctrl.run_written <= it12_pkg::RUN_RESET;
      ctrl.cmp <= it12_pkg::CMP_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ---------------------------------------------------------------
  // counter and interrupt pulse
  // ---------------------------------------------------------------
  // period is (compare + 1) count ticks; compare 0 is prohibited to software
  always_comb begin
    next_count = count;
    next_irq = 1'b0;
    if (!gate || !ctrl.run_applied) begin
      next_count = '0; // stopped counter is cleared
    end else if (tick) begin // counting on the count clock
      if (match) begin
        next_count = '0; // clear and keep counting
        next_irq = 1'b1; // same count cycle as the clear
      end else begin
        next_count = count + 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
      irq <= 1'b0;
    end else begin
      count <= next_count;
      irq <= next_irq; // single cpu-clock pulse per match
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // gated off, the control word reads as its default value
  always_comb begin
    next_rdata = rdata;
    if (sfr_req_i.rd) begin
      if (sfr_req_i.addr == PER_ADDR) begin
        next_rdata = {8'h00, peripheral_clock_gates};
      end else if (sfr_req_i.addr == it12_pkg::CTRL_WORD_ADDR) begin
        if (gate) begin
          next_rdata = {ctrl.run_applied, 3'h0, ctrl.cmp};
        end else begin
          next_rdata = it12_pkg::CTRL_WORD_RESET;
        end
      end else begin
        next_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign sfr_rdata_o = rdata;
  assign low_speed_peripheral_clock_gate_o = gate;
  assign count_run_enable_o = ctrl.run_applied;
  assign interval_interrupt_request_o = irq;

endmodule

// *** design/it12_pkg.sv ***
// Purpose: constants and types shared by the 12-bit interval timer
// Assumes: a simple native SFR port from the CPU, one 16-bit word per access
// Notes: addresses are SFR byte addresses, reads return data one cycle later
package it12_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [19:0] CTRL_WORD_ADDR = 20'hFFF90; // interval control word
  localparam logic [19:0] PER_ADDR_DEFAULT = 20'hF00F0; // peripheral clock gates

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int CMP_W = 12;
  localparam int RUN_BIT = 15;
  localparam int GATE_BIT = 7;
  localparam logic [7:0] PER_RESET = 8'h00;
  localparam logic [CMP_W-1:0] CMP_RESET = 12'hFFF;
  localparam logic RUN_RESET = 1'b0;
  localparam logic [15:0] CTRL_WORD_RESET = 16'h0FFF;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } it12_sfr_req_t;

  typedef struct packed {
    logic run_applied;
    logic run_written;
    logic [CMP_W-1:0] cmp;
  } it12_ctrl_t;

endpackage

// *** design/it12_tick_sync.sv ***
// Purpose: bring the low-speed count clock into the CPU clock domain
// Assumes: count clock far slower than sys_clk_i
// Notes: emits one sys_clk_i pulse per rising edge of the count clock
`timescale 1ns/1ns
module it12_tick_sync (
  input wire logic sys_clk_i, // cpu clock
  input wire logic resetn_i, // async reset, active low
  input wire logic cnt_clk_i, // low-speed count clock pin
  output logic tick_o // one pulse per count clock rise
);

  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // two-stage synchroniser, then a delayed copy for the edge
  always_comb begin
    next_meta = cnt_clk_i;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign tick_o = sync & ~prev; // rising edge of the synchronised clock

endmodule

// *** sim/it12_interval_timer_sva.sv ***
// Purpose: port checks for the 12-bit interval timer
// Assumes: one sys_clk_i domain
// Notes: bound to every timer instance
`timescale 1ns/1ns
module it12_interval_timer_sva #(
  parameter logic [19:0] PER_ADDR = it12_pkg::PER_ADDR_DEFAULT // gate register address
) (
  input wire logic sys_clk_i, // cpu clock
  input wire logic resetn_i, // reset, active low
  input wire logic cnt_clk_i, // count clock
  input wire it12_pkg::it12_sfr_req_t sfr_req_i, // register access
  input wire logic [15:0] sfr_rdata_o, // read data
  input wire logic low_speed_peripheral_clock_gate_o, // gate bit
  input wire logic count_run_enable_o, // run enable
  input wire logic interval_interrupt_request_o // match pulse
);
  // ---------------------------------------------------------------
  // shorthands and sequences
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic gate = low_speed_peripheral_clock_gate_o;
  wire logic irq = interval_interrupt_request_o;
  wire logic ctl = sfr_req_i.addr == it12_pkg::CTRL_WORD_ADDR;
  wire logic per = sfr_req_i.addr == PER_ADDR;
  sequence gate_wr_s;
    sfr_req_i.wr && per;
  endsequence
  sequence ctl_rd_s;
    sfr_req_i.rd && ctl;
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  irq_pulse_a: assert property (irq |=> !irq) else $error("irq longer than one cycle");
  irq_gated_a: assert property (irq |-> $past(gate)) else $error("irq while gated");
  irq_clock_a: assert property (irq |-> $past(cnt_clk_i, 3) && !$past(cnt_clk_i, 4))
    else $error("irq without a count clock rise");
  gate_hold_a: assert property (!gate |=> !irq) else $error("irq from gated timer");
  gate_off_a: assert property (!gate |=> !count_run_enable_o) else $error("run while gated");
  ctl_lock_a: assert property (ctl_rd_s ##0 !gate |=> sfr_rdata_o == 16'h0FFF)
    else $error("gated control word not at reset value");
  ctl_read_a: assert property (ctl_rd_s ##0 gate |=> sfr_rdata_o[15] == $past(count_run_enable_o)
    && sfr_rdata_o[14:12] == 3'h0) else $error("control word readback wrong");
  gate_bit_a: assert property (gate_wr_s |=> gate == $past(sfr_req_i.wdata[7]))
    else $error("gate bit not taken from bit 7");
  gate_read_a: assert property (sfr_req_i.rd && per |=> sfr_rdata_o[15:8] == 8'h00
    && sfr_rdata_o[7] == $past(gate)) else $error("gate register readback wrong");
  unmapped_a: assert property (sfr_req_i.rd && !ctl && !per |=> sfr_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind it12_interval_timer it12_interval_timer_sva #(.PER_ADDR(PER_ADDR)) i_sva (.sys_clk_i,
  .resetn_i, .cnt_clk_i, .sfr_req_i, .sfr_rdata_o, .low_speed_peripheral_clock_gate_o,
  .count_run_enable_o, .interval_interrupt_request_o);

// *** sim/testbench.sv ***
// Purpose: self-checking bench for the 12-bit interval timer
// Assumes: default gate register address
// Notes: a tick model is synced on the first match pulse
`timescale 1ns/1ns
module testbench;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cnt_clk_i = 1'b0;
  it12_pkg::it12_sfr_req_t req = '0;
  logic [15:0] rdata;
  logic gate, run, irq;
  int bad_count = 0, tests_run = 0, irq_n = 0, seed = 32'h9737, cmp, cnt, got, i;
  localparam logic [19:0] CA = it12_pkg::CTRL_WORD_ADDR;
  localparam logic [19:0] PA = it12_pkg::PER_ADDR_DEFAULT;
  it12_interval_timer i_dut (.sys_clk_i, .resetn_i, .cnt_clk_i, .sfr_req_i(req),
    .sfr_rdata_o(rdata), .low_speed_peripheral_clock_gate_o(gate),
    .count_run_enable_o(run), .interval_interrupt_request_o(irq));
  // ---------------------------------------------------------------
  // clock, pulse counter and tasks
  // ---------------------------------------------------------------
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // count match pulses mid-cycle, where the registered pulse is settled
  always @(negedge sys_clk_i) begin
    if (irq === 1'b1) irq_n++;
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [19:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge sys_clk_i);
    req.wr = 1'b0;
  endtask
  task rd(input logic [19:0] a, input logic [15:0] exp);
    @(negedge sys_clk_i);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge sys_clk_i);
    req.rd = 1'b0;
    chk("read data", exp, rdata);
  endtask
  task tick(output int n);
    n = irq_n;
    @(negedge sys_clk_i) cnt_clk_i = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    cnt_clk_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    n = irq_n - n;
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    begin : main_seq
      repeat (20) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      rd(CA, 16'h0FFF);
      rd(PA, 16'h0000);
      chk("gate after reset", 16'h0000, {15'h0000, gate});
      wr(CA, 16'h8005);
      rd(CA, 16'h0FFF);
      rd(20'h00000, 16'h0000);
      wr(PA, 16'h0080);
      rd(PA, 16'h0080);
      chk("gate bit", 16'h0001, {15'h0000, gate});
      for (int k = 0; k < 3; k++) begin
        cmp = 1 + ($unsigned($random(seed)) % 6);
        wr(CA, 16'hF000 | cmp[15:0]);
        rd(CA, cmp[15:0]);
        tick(got);
        rd(CA, 16'h8000 | cmp[15:0]);
        i = 0;
        while (got == 0 && i < cmp + 2) begin
          tick(got);
          i++;
        end
        chk("first match pulse", 16'h0001, got[15:0]);
        if (got == 0) disable main_seq;
        cnt = 0;
        repeat (2 * (cmp + 1)) begin
          tick(got);
          cnt = (cnt == cmp) ? 0 : cnt + 1;
          chk("pulse per tick", (cnt == 0) ? 16'h0001 : 16'h0000, got[15:0]);
        end
        wr(CA, cmp[15:0]);
        tick(got);
        tick(got);
        chk("pulse after stop", 16'h0000, got[15:0]);
        rd(CA, cmp[15:0]);
      end
      wr(CA, 16'h8002);
      tick(got);
      tick(got);
      wr(PA, 16'h0000);
      rd(CA, 16'h0FFF);
      chk("run after gate off", 16'h0000, {15'h0000, run});
      chk("gate bit off", 16'h0000, {15'h0000, gate});
      wr(CA, 16'h8001);
      tick(got);
      tick(got);
      tick(got);
      chk("pulse while gated", 16'h0000, got[15:0]);
      chk("run while gated", 16'h0000, {15'h0000, run});
      wr(PA, 16'h0080);
      rd(CA, 16'h0FFF);
    end
    print_verdict();
  end
endmodule
